// file: logic/cst_defines.vh
// constants for the coast stop and external trip block
// assumes a 100 MHz clock and a 32-bit classic wishbone slave
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH
// register byte offsets
`define CST_REG_CTRL 8'h00
`define CST_REG_DELAY 8'h04
`define CST_REG_FUNC 8'h08
`define CST_REG_POL 8'h0c
`define CST_REG_STATUS 8'h10
`define CST_REG_IRQ_STAT 8'h14
`define CST_REG_IRQ_MASK 8'h18
`define CST_REG_HIST 8'h1c
`define CST_REG_CMD 8'h20
// ctrl fields
`define CST_CTRL_SPEED_SEL 0
`define CST_CTRL_GUARD 1
// interrupt event bits
`define CST_IRQ_TRIP 0
`define CST_IRQ_COAST 1
`define CST_IRQ_RESTART 2
// terminal function codes
`define CST_FN_COAST 5'h0b
`define CST_FN_FAULT 5'h0c
`define CST_FN_RESET 5'h12
// fault code shown while tripped
`define CST_FAULT_CODE 8'h0c
// reset values
`define CST_FUNC_RST 32'h0000_0000
`define CST_POL_RST 6'h00
// timing: delay unit is 1 ms, clock period 10 ns
`define CST_DELAY_UNIT_NS 1000000
`define CST_CLK_NS 10
`define CST_PU_SETTLE 2'h3
`endif

// file: logic/cst_coast_trip.v
// coast stop and external trip control for a motor drive
// assumes async terminal pins, wishbone master on same clock
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "cst_defines.vh"
module cst_coast_trip #(
	parameter TICK_CYCLES = `CST_DELAY_UNIT_NS / `CST_CLK_NS,
	parameter NUM_IN = 6,
	parameter SPD_W = 16
) (
	input wire clock,
	input wire reset_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [NUM_IN-1:0] term_in,
	input wire run_cmd_in,
	input wire keypad_reset_in,
	input wire [SPD_W-1:0] motor_speed_in,
	output reg gate_on_ff,
	output reg ramp_run_ff,
	output reg [SPD_W-1:0] start_freq_ff,
	output reg restart_ff,
	output reg alarm_ff,
	output reg [7:0] fault_code_ff,
	output reg irq_ff
);
	// one-hot states
	localparam [6:0] ST_STOP = 7'h01;
	localparam [6:0] ST_RUN = 7'h02;
	localparam [6:0] ST_COAST = 7'h04;
	localparam [6:0] ST_WAIT = 7'h08;
	localparam [6:0] ST_TRIP = 7'h10;
	localparam [6:0] ST_RSTH = 7'h20;
	localparam [6:0] ST_GUARD = 7'h40;

	// true if any input carrying this code is active
	function fn_active;
		input [NUM_IN-1:0] lvl;
		input [5*NUM_IN-1:0] map;
		input [4:0] code;
		integer i;
		begin
			fn_active = 1'b0;
			for (i = 0; i < NUM_IN; i = i + 1)
				if (lvl[i] && map[5*i +: 5] == code)
					fn_active = 1'b1;
		end
	endfunction

	// software registers
	reg speed_sel_ff; // restart from speed
	reg guard_ff; // power-on run guard
	reg [15:0] delay_ff; // restart delay, ms
	reg [31:0] func_ff; // input function map
	reg [NUM_IN-1:0] pol_ff; // input polarity
	reg [2:0] irq_stat_ff; // sticky events
	reg [2:0] irq_mask_ff; // event enables
	reg soft_rst_ff; // software reset level
	reg [7:0] hist_ff; // trip history count

	// synchronisers, first stage read only by second
	reg [NUM_IN+1:0] sync1_ff;
	reg [NUM_IN+1:0] sync2_ff;

	// control state
	reg [6:0] state_ff;
	reg [6:0] nxt_state;
	reg fault_prev_ff; // fault edge detect
	reg rst_prev_ff; // reset release detect
	reg run_prev_ff; // run edge detect
	reg decel_ff; // controlled stop running
	reg [1:0] pu_cnt_ff; // power-up settle
	reg pu_done_ff; // power-up check done
	reg [15:0] dly_cnt_ff; // delay units left
	reg [31:0] tick_cnt_ff; // cycles per unit
	reg nxt_restart;
	reg [2:0] ev_set;

	// polarity-corrected terminals
	wire [NUM_IN-1:0] term_lvl = sync2_ff[NUM_IN-1:0] ^ pol_ff;
	wire run_lvl = sync2_ff[NUM_IN];
	wire key_lvl = sync2_ff[NUM_IN+1];
	wire [5*NUM_IN-1:0] fmap = func_ff[5*NUM_IN-1:0];
	wire coast_on = fn_active(term_lvl, fmap, `CST_FN_COAST);
	wire fault_on = fn_active(term_lvl, fmap, `CST_FN_FAULT);
	wire rst_on = fn_active(term_lvl, fmap, `CST_FN_RESET) | key_lvl | soft_rst_ff;
	wire fault_rise = fault_on & ~fault_prev_ff;
	wire rst_fall = rst_prev_ff & ~rst_on;
	wire run_rise = run_lvl & ~run_prev_ff;
	wire tick = (tick_cnt_ff == 32'h0000_0000);
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;

	// two-stage input synchroniser
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			sync1_ff <= {(NUM_IN+2){1'b0}};
			sync2_ff <= {(NUM_IN+2){1'b0}};
		end
		else
		begin
			sync1_ff <= {keypad_reset_in, run_cmd_in, term_in};
			sync2_ff <= sync1_ff;
		end
	end

	// next state and events
	always @*
	begin
		nxt_state = state_ff;
		nxt_restart = 1'b0;
		ev_set = 3'h0;
		if (fault_rise && state_ff != ST_TRIP)
		begin
			// fault wins over every other cause
			nxt_state = ST_TRIP;
			ev_set[`CST_IRQ_TRIP] = 1'b1;
		end
		else
		begin
			case (state_ff)
			ST_STOP:
				if (!pu_done_ff)
				begin
					// ignore run held at power-up
					if (pu_cnt_ff == `CST_PU_SETTLE && run_lvl && guard_ff)
						nxt_state = ST_GUARD;
				end
				else if (coast_on)
					nxt_state = ST_COAST;
				else if (run_lvl)
				begin
					nxt_state = ST_RUN;
					nxt_restart = 1'b1;
				end
			ST_RUN:
				if (coast_on)
				begin
					nxt_state = ST_COAST;
					ev_set[`CST_IRQ_COAST] = 1'b1;
				end
				else if (!run_lvl)
					nxt_state = ST_STOP;
			ST_COAST:
				if (!coast_on)
				begin
					if (!run_lvl)
						nxt_state = ST_STOP;
					else if (delay_ff == 16'h0000)
					begin
						nxt_state = ST_RUN;
						nxt_restart = 1'b1;
					end
					else
						nxt_state = ST_WAIT;
				end
			ST_WAIT:
				if (coast_on)
					nxt_state = ST_COAST;
				else if (!run_lvl)
					nxt_state = ST_STOP;
				else if (dly_cnt_ff == 16'h0000)
				begin
					nxt_state = ST_RUN;
					nxt_restart = 1'b1;
				end
			ST_TRIP:
				// held until a reset, fault level ignored
				if (rst_on)
					nxt_state = ST_RSTH;
			ST_RSTH:
				if (!rst_on)
					nxt_state = guard_ff ? ST_GUARD : ST_STOP;
			ST_GUARD:
				if (run_rise)
				begin
					nxt_state = ST_RUN;
					nxt_restart = 1'b1;
				end
				else if (rst_fall || !run_lvl)
					nxt_state = ST_STOP;
			default:
				nxt_state = ST_STOP;
			endcase
		end
		if (nxt_restart)
			ev_set[`CST_IRQ_RESTART] = 1'b1;
	end

	// state, edges, power-up window
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			state_ff <= ST_STOP;
			fault_prev_ff <= 1'b0;
			rst_prev_ff <= 1'b0;
			run_prev_ff <= 1'b0;
			pu_cnt_ff <= 2'h0;
			pu_done_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			fault_prev_ff <= fault_on;
			rst_prev_ff <= rst_on;
			run_prev_ff <= run_lvl;
			// wait for the synchroniser to fill
			if (pu_cnt_ff != `CST_PU_SETTLE)
				pu_cnt_ff <= pu_cnt_ff + 2'h1;
			else
				pu_done_ff <= 1'b1;
		end
	end

	// restart delay timer, unit prescaler
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			dly_cnt_ff <= 16'h0000;
			tick_cnt_ff <= 32'h0000_0000;
		end
		else if (state_ff == ST_COAST)
		begin
			// reload on every coast cycle, so release starts fresh
			dly_cnt_ff <= delay_ff;
			tick_cnt_ff <= TICK_CYCLES - 1;
		end
		else if (state_ff == ST_WAIT && dly_cnt_ff != 16'h0000)
		begin
			if (tick)
			begin
				tick_cnt_ff <= TICK_CYCLES - 1;
				dly_cnt_ff <= dly_cnt_ff - 16'h0001;
			end
			else
				tick_cnt_ff <= tick_cnt_ff - 32'h0000_0001;
		end
	end

	// drive outputs, all registered
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			gate_on_ff <= 1'b0;
			ramp_run_ff <= 1'b0;
			start_freq_ff <= {SPD_W{1'b0}};
			restart_ff <= 1'b0;
			alarm_ff <= 1'b0;
			fault_code_ff <= 8'h00;
			decel_ff <= 1'b0;
		end
		else
		begin
			restart_ff <= nxt_restart;
			if (nxt_restart)
				// speed pickup on every restart except one made from stop
				start_freq_ff <= (speed_sel_ff && state_ff != ST_STOP) ?
					motor_speed_in : {SPD_W{1'b0}};
			// keep gate on while ramping down from run
			if (state_ff == ST_RUN && nxt_state == ST_STOP)
				decel_ff <= 1'b1;
			else if (nxt_state != ST_STOP || motor_speed_in == {SPD_W{1'b0}})
				decel_ff <= 1'b0;
			gate_on_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_STOP &&
				(decel_ff || state_ff == ST_RUN));
			ramp_run_ff <= (nxt_state == ST_RUN);
			alarm_ff <= (nxt_state == ST_TRIP);
			fault_code_ff <= (nxt_state == ST_TRIP) ? `CST_FAULT_CODE : 8'h00;
		end
	end

	// trip history, cleared by a reset command
	always @(posedge clock)
	begin
		if (!reset_n)
			hist_ff <= 8'h00;
		else if (ev_set[`CST_IRQ_TRIP] && hist_ff != 8'hff)
			hist_ff <= hist_ff + 8'h01;
		else if (rst_on && !ev_set[`CST_IRQ_TRIP])
			hist_ff <= 8'h00;
	end

	// register writes, byte lane 0 style per field
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			speed_sel_ff <= 1'b0;
			guard_ff <= 1'b0;
			delay_ff <= 16'h0000;
			func_ff <= `CST_FUNC_RST;
			pol_ff <= `CST_POL_RST;
			irq_mask_ff <= 3'h0;
			soft_rst_ff <= 1'b0;
		end
		else if (bus_wr)
		begin
			case (wb_adr_i)
			`CST_REG_CTRL:
				if (wb_sel_i[0])
				begin
					speed_sel_ff <= wb_dat_i[`CST_CTRL_SPEED_SEL];
					guard_ff <= wb_dat_i[`CST_CTRL_GUARD];
				end
			`CST_REG_DELAY:
			begin
				if (wb_sel_i[0])
					delay_ff[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					delay_ff[15:8] <= wb_dat_i[15:8];
			end
			`CST_REG_FUNC:
			begin
				if (wb_sel_i[0])
					func_ff[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					func_ff[15:8] <= wb_dat_i[15:8];
				if (wb_sel_i[2])
					func_ff[23:16] <= wb_dat_i[23:16];
				if (wb_sel_i[3])
					func_ff[31:24] <= wb_dat_i[31:24];
			end
			`CST_REG_POL:
				if (wb_sel_i[0])
					pol_ff <= wb_dat_i[NUM_IN-1:0];
			`CST_REG_IRQ_MASK:
				if (wb_sel_i[0])
					irq_mask_ff <= wb_dat_i[2:0];
			`CST_REG_CMD:
				if (wb_sel_i[0])
					soft_rst_ff <= wb_dat_i[0];
			default:
				soft_rst_ff <= soft_rst_ff;
			endcase
		end
	end

	// sticky events, set beats write-one clear
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			irq_stat_ff <= 3'h0;
			irq_ff <= 1'b0;
		end
		else
		begin
			if (bus_wr && wb_adr_i == `CST_REG_IRQ_STAT && wb_sel_i[0])
				irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[2:0]) | ev_set;
			else
				irq_stat_ff <= irq_stat_ff | ev_set;
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	// wishbone answer, one cycle after request
	always @(posedge clock)
	begin
		if (!reset_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i)
			begin
				case (wb_adr_i)
				`CST_REG_CTRL:
					wb_dat_o <= {30'h0, guard_ff, speed_sel_ff};
				`CST_REG_DELAY:
					wb_dat_o <= {16'h0000, delay_ff};
				`CST_REG_FUNC:
					wb_dat_o <= func_ff;
				`CST_REG_POL:
					wb_dat_o <= {{(32-NUM_IN){1'b0}}, pol_ff};
				`CST_REG_STATUS:
					wb_dat_o <= {16'h0000, fault_code_ff, 1'b0, state_ff};
				`CST_REG_IRQ_STAT:
					wb_dat_o <= {29'h0, irq_stat_ff};
				`CST_REG_IRQ_MASK:
					wb_dat_o <= {29'h0, irq_mask_ff};
				`CST_REG_HIST:
					wb_dat_o <= {24'h0, hist_ff};
				`CST_REG_CMD:
					wb_dat_o <= {31'h0, soft_rst_ff};
				default:
					// unmapped reads return zero
					wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// file: verif/cst_coast_trip_checker.sv
// checker for the coast stop and trip block, ports only
// assumes resets come from keypad_reset_in alone in this bench
`timescale 1ns/1ns
module cst_coast_trip_checker (
	input wire clock,
	input wire reset_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire [31:0] wb_dat_o,
	input wire keypad_reset_in,
	input wire gate_on_ff,
	input wire ramp_run_ff,
	input wire restart_ff,
	input wire alarm_ff,
	input wire [7:0] fault_code_ff,
	input wire irq_ff
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// keypad history over the synchroniser depth, starts busy so no early claim
	logic [2:0] kp_hist_ff = 3'h7;
	// shift in the keypad level on every edge
	always @(posedge clock)
		kp_hist_ff <= {kp_hist_ff[1:0], keypad_reset_in};
	// keypad quiet now and for the last three edges
	wire kp_quiet = !keypad_reset_in && (kp_hist_ff == 3'h0);
	a_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not zero");
	a_alarm_code: assert property (alarm_ff == (fault_code_ff == 8'h0c)) else $error("code mismatch");
	a_trip_gate_off: assert property (alarm_ff |-> !gate_on_ff) else $error("gate during trip");
	a_ramp_gate: assert property (ramp_run_ff |-> gate_on_ff) else $error("ramp unpowered");
	a_restart_pulse: assert property (restart_ff |-> gate_on_ff ##1 !restart_ff) else $error("bad restart");
	a_alarm_hold: assert property (alarm_ff && kp_quiet |=> alarm_ff) else $error("trip lost");
	c_trip: cover property ($rose(alarm_ff));
	c_restart: cover property (restart_ff);
	c_irq: cover property ($rose(irq_ff));
endmodule
bind cst_coast_trip cst_coast_trip_checker u_chk (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .keypad_reset_in(keypad_reset_in),
	.gate_on_ff(gate_on_ff), .ramp_run_ff(ramp_run_ff), .restart_ff(restart_ff), .alarm_ff(alarm_ff),
	.fault_code_ff(fault_code_ff), .irq_ff(irq_ff));

// file: verif/cst_motor_model.sv
// motor and power stage seen from the drive
// assumes the drive's gate and ramp outputs on the same clock
`timescale 1ns/1ns
module cst_motor_model (
	input wire clock,
	input wire reset_n,
	input wire gate_on,
	input wire ramp_run,
	output logic [15:0] speed_ff
);
	// speed climbs under ramp, falls otherwise
	always @(posedge clock)
	begin
		if (!reset_n)
			speed_ff <= 16'h0;
		else if (gate_on && ramp_run && speed_ff < 16'h0040)
			speed_ff <= speed_ff + 16'h1;
		else if (!(gate_on && ramp_run) && speed_ff != 16'h0)
			speed_ff <= speed_ff - 16'h1; // coast or ramp down
	end
endmodule

// file: verif/test_cst_coast_trip.sv
// self-checking bench for the coast stop and trip block
// assumes a short delay tick so waits stay small
`timescale 1ns/1ns
module test_cst_coast_trip;
	logic clock = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, run = 0, kp = 0;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0, q;
	logic [5:0] term = 6'h0;
	wire [31:0] rdat;
	wire [15:0] spd, sfreq;
	wire [7:0] code;
	wire ack, gate, ramp, rst_p, alarm, irq;
	int fails = 0, checked = 0, cycles = 0, restarts = 0;
	always #5 clock = ~clock;
	// count restart pulses, each stands one cycle
	always @(posedge clock)
		if (rst_p === 1'b1)
			restarts++;
	cst_coast_trip #(.TICK_CYCLES(4)) uut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.term_in(term), .run_cmd_in(run), .keypad_reset_in(kp), .motor_speed_in(spd), .gate_on_ff(gate),
		.ramp_run_ff(ramp), .start_freq_ff(sfreq), .restart_ff(rst_p), .alarm_ff(alarm),
		.fault_code_ff(code), .irq_ff(irq));
	cst_motor_model u_motor (.clock(clock), .reset_n(reset_n), .gate_on(gate), .ramp_run(ramp), .speed_ff(spd));
	task stop_test;
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			stop_test;
		end
	end
	task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// one classic cycle, held until ack
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do @(posedge clock); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	// pins move after an edge, then settle
	task pins(input logic [5:0] t, input logic r, input logic k, input int n);
		@(posedge clock);
		{term, run, kp} <= {t, r, k};
		repeat (n) @(posedge clock);
	endtask
	task t_regs;
		bus(0, 8'h00, 0); cmp("ctrl", 32'h0, q);
		bus(0, 8'h30, 0); cmp("unmapped", 32'h0, q);
		bus(1, 8'h08, 32'h0000_498b); // t0 coast, t1 fault, t2 reset
		bus(0, 8'h08, 0); cmp("func", 32'h0000_498b, q);
		bus(1, 8'h18, 32'h1);
	endtask
	task t_coast;
		pins(6'h0, 1, 0, 80); cmp("run gate", 1, gate);
		pins(6'h1, 1, 0, 6); cmp("coast gate", 0, gate);
		bus(1, 8'h04, 32'h2); bus(1, 8'h00, 32'h1);
		pins(6'h0, 1, 0, 6); cmp("delay wait", 0, gate);
		pins(6'h0, 1, 0, 8); cmp("resume", 1, gate);
		cmp("pickup", 1, sfreq != 16'h0);
		cmp("restarts", 2, restarts);
		pins(6'h0, 0, 0, 6); cmp("decel gate", 1, gate); cmp("decel ramp", 0, ramp);
		pins(6'h0, 0, 0, 80); cmp("stopped", 0, gate);
		bus(1, 8'h0c, 32'h1); pins(6'h0, 1, 0, 8); cmp("low coast", 0, gate);
		pins(6'h1, 1, 0, 40); cmp("low release", 1, gate);
		bus(1, 8'h00, 32'h0); bus(1, 8'h0c, 32'h0);
		pins(6'h0, 1, 0, 14); cmp("zero restart", 0, sfreq);
	endtask
	task t_trip(input logic guard);
		bus(1, 8'h00, {30'h0, guard, 1'b0});
		pins(6'h2, 1, 0, 6); cmp("alarm", 1, alarm); cmp("code", 8'h0c, code);
		cmp("trip gate", 0, gate); cmp("irq", 1, irq);
		pins(6'h0, 1, 0, 8); cmp("alarm held", 1, alarm);
		bus(0, 8'h1c, 0); cmp("hist", 32'h1, q);
		bus(0, 8'h10, 0); cmp("status", 32'h0000_0c10, q);
		pins(6'h0, 1, 1, 8); cmp("alarm clr", 0, alarm); cmp("code clr", 0, code);
		bus(0, 8'h1c, 0); cmp("hist clr", 32'h0, q);
		pins(6'h0, 1, 0, 8); cmp("after reset", !guard, gate);
		if (guard)
		begin
			pins(6'h0, 0, 0, 6); pins(6'h0, 1, 0, 8); cmp("new run", 1, gate);
		end
		bus(1, 8'h14, 32'h7); bus(0, 8'h14, 0); cmp("stat clr", 32'h0, q);
		@(posedge clock); cmp("irq clr", 0, irq);
	endtask
	// reset in mid-run with run held, guard set at once
	task t_powerup;
		@(posedge clock);
		{reset_n, run} <= 2'b01;
		repeat (2) @(posedge clock);
		reset_n <= 1;
		bus(1, 8'h00, 32'h2);
		pins(6'h0, 1, 0, 12); cmp("guard hold", 0, gate);
		pins(6'h0, 1, 1, 6); pins(6'h0, 1, 0, 8); cmp("guard reset", 1, gate);
	endtask
	initial
	begin
		repeat (2) @(posedge clock);
		reset_n <= 1;
		t_regs;
		t_coast;
		t_trip(0);
		t_trip(1);
		t_powerup;
		stop_test;
	end
endmodule
